// *** hdl/ssq_pkg.sv ***
/*
 * shared constants for the bus command sequencer: command codes, field
 * positions, timing figures and the sequencer state type.
 * assumes a 10 MHz core clock and an 8-bit command register image.
 */
`default_nettype none

package ssq_pkg;
	// ==========================================================
	// command register layout
	localparam int CODE_MSB = 4; // code field top bit
	localparam int CODE_LSB = 0; // code field bottom bit
	localparam int TC_W = 24; // transfer counter width
	localparam int ID_W = 3; // destination id width

	// ==========================================================
	// command codes
	localparam logic [4:0] CMD_RESET = 5'h00;
	localparam logic [4:0] CMD_DISC = 5'h01;
	localparam logic [4:0] CMD_PAUSE = 5'h02;
	localparam logic [4:0] CMD_SETATN = 5'h03;
	localparam logic [4:0] CMD_MSGACC = 5'h04;
	localparam logic [4:0] CMD_DISABLE = 5'h05;
	localparam logic [4:0] IMM_LAST = 5'h07; // last immediate code
	localparam logic [4:0] CMD_SEL_ATN = 5'h08;
	localparam logic [4:0] CMD_SEL = 5'h09;
	localparam logic [4:0] CMD_RESEL = 5'h0A;
	localparam logic [4:0] INT_LAST = 5'h15; // last valid code

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 100; // 10 MHz
	localparam int TICK_CYC = 1024; // timeout interval in clocks
	localparam int TICK_W = 10;
	localparam int HOLD_MIN_NS = 100000; // 100 us selection hold
	localparam int HOLD_CYC =
		(HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_W = 10;

	// ==========================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_DISC, // disconnected idle
		ST_INIT, // connected as initiator
		ST_TGT, // connected as target
		ST_ARB, // arbitrating for select or reselect
		ST_SELP, // selection phase, awaiting busy
		ST_PHOLD, // pause: ids dropped, selection held
		ST_PBSY, // pause: waiting for busy to clear
		ST_OFF // disabled until reset
	} ssq_state_e;
endpackage

`default_nettype wire

// *** hdl/ssq_sequencer.sv ***
/*
 * command sequencer of a bus protocol controller: immediate commands,
 * select and reselect with arbitration, pause and selection timeout.
 * assumes arbitration, phase decode and the byte datapath live outside
 * and report through the sense inputs, all synchronous to CLK_I.
 */
// Functional notes
// - chip reset command equals hardware reset
// - disconnect releases bus; ignored when disconnected
// - pause valid only disconnected or target
// - target pause aborts transfer within one byte
// - paused transfer keeps remaining count, resumable
// - pause before arbitration won: paused, disconnected
// - pause after win: hold selection 100us, release
// - interrupt events win over pending pause
// - disconnected pause sets paused unless selected or reselected
// - set attention only as initiator
// - message out end drops attention
// - attention on select-atn win or parity
// - message in end: complete, keep ack
// - message accepted drops held ack, initiator
// - disable tristates, ignores all but reset
// - select outside disconnected gives invalid
// - timeout is count times 1024 clocks
// - selected while arbitrating abandons own command
// - selection phase, timer, disconnect or complete
// - low eight codes immediate, rest interrupting
// - immediate commands, but a target pause, act within three clocks
`default_nettype none

module ssq_sequencer (
	input wire logic CLK_I, // core clock
	input wire logic NRST_I, // synchronous reset, active low
	input wire logic CE_I, // clock enable, freezes all state
	input wire logic CMD_WR_I, // command register write strobe
	input wire logic [7:0] CMD_I, // command register image
	input wire logic TC_LOAD_I, // transfer counter load strobe
	input wire logic [23:0] TC_I, // transfer counter load value
	input wire logic [2:0] DEST_ID_I, // destination id register
	input wire logic ARB_WON_I, // arbitration won
	input wire logic SELECTED_I, // we are being selected
	input wire logic RESELECTED_I, // we are being reselected
	input wire logic BSY_IN_I, // busy_in_sense
	input wire logic ATN_IN_I, // attention seen as target
	input wire logic XFER_ACTIVE_I, // send or receive running
	input wire logic BYTE_DONE_I, // byte transfer cycle ended
	input wire logic MSGOUT_DONE_I, // message out count exhausted
	input wire logic MSGIN_LAST_I, // last message in byte taken
	input wire logic PAR_ERR_I, // parity error on input byte
	output logic [2:0] STATE_O, // sequencer state
	output logic BUS_OE_O, // bus drivers enabled
	output logic ARB_REQ_O, // request arbitration
	output logic SEL_OUT_O, // selection_out_drive
	output logic ID_DRV_O, // drive own and destination id bits
	output logic [2:0] DEST_ID_O, // latched destination id
	output logic ATN_O, // attention drive
	output logic ACK_HOLD_O, // ack held after message in
	output logic XFER_ABORT_O, // pulse: abort send or receive
	output logic PAUSED_O, // paused status
	output logic [23:0] TC_O, // transfer counter
	output logic INT_FC_O, // pulse: function complete
	output logic INT_DISC_O, // pulse: disconnected
	output logic INT_INV_O, // pulse: invalid command
	output logic INT_SEL_O, // pulse: selected
	output logic INT_RESEL_O, // pulse: reselected
	output logic INT_BSVC_O // pulse: bus service
);
	// ==========================================================
	// state record
	typedef struct packed {
		ssq_pkg::ssq_state_e st; // sequencer state
		logic atn_sel; // select variant with attention
		logic resel; // reselect variant
		logic pflag; // pause seen, not yet acted on
		logic to_en; // timeout armed
		logic [ssq_pkg::TC_W-1:0] tc; // transfer counter
		logic [ssq_pkg::TICK_W-1:0] tick; // interval prescaler
		logic [ssq_pkg::HOLD_W-1:0] hold; // selection hold count
		logic [ssq_pkg::ID_W-1:0] dest; // latched destination
		logic oe, arb, sel_out, id_drv, atn, ack_hold;
		logic paused, abort;
		logic i_fc, i_disc, i_inv, i_sel, i_resel, i_bsvc;
	} ssq_s;

	localparam ssq_s RST = '{st: ssq_pkg::ST_DISC, oe: 1'b1,
		default: '0};

	ssq_s q; // registered state
	ssq_s d; // next state
	logic [4:0] code; // command code field
	logic wr; // command write this cycle

	// ==========================================================
	// command decode
	// immediate class: the low eight codes
	function automatic logic is_imm(input logic [4:0] c);
		return c <= ssq_pkg::IMM_LAST;
	endfunction

	// the three codes that start arbitration
	function automatic logic is_sel(input logic [4:0] c);
		return c == ssq_pkg::CMD_SEL_ATN || c == ssq_pkg::CMD_SEL ||
			c == ssq_pkg::CMD_RESEL;
	endfunction

	assign code = CMD_I[ssq_pkg::CODE_MSB:ssq_pkg::CODE_LSB];
	assign wr = CMD_WR_I;

	// ==========================================================
	// next-state logic
	// every immediate command but a pause in ST_ARB, ST_SELP or ST_TGT is decided
	// here in the write cycle and lands at the next edge, one clock after the write
	always_comb begin
		d = q;
		// interrupt and abort flags are single-cycle pulses
		d.i_fc = 1'b0;
		d.i_disc = 1'b0;
		d.i_inv = 1'b0;
		d.i_sel = 1'b0;
		d.i_resel = 1'b0;
		d.i_bsvc = 1'b0;
		d.abort = 1'b0;
		if (q.st != ssq_pkg::ST_OFF && TC_LOAD_I) begin
			d.tc = TC_I;
		end
		// a new command clears a stale paused status
		if (q.st != ssq_pkg::ST_OFF && wr) begin
			d.paused = 1'b0;
		end
		case (q.st)
			ssq_pkg::ST_DISC: begin
				if (SELECTED_I) begin
					// being selected: become target
					d.st = ssq_pkg::ST_TGT;
					d.i_sel = 1'b1;
					d.i_bsvc = ATN_IN_I;
				end else if (RESELECTED_I) begin
					d.st = ssq_pkg::ST_INIT;
					d.i_resel = 1'b1;
				end else if (wr && code == ssq_pkg::CMD_PAUSE) begin
					d.paused = 1'b1;
				end else if (wr && is_sel(code)) begin
					d.st = ssq_pkg::ST_ARB;
					d.arb = 1'b1;
					d.atn_sel = code == ssq_pkg::CMD_SEL_ATN;
					d.resel = code == ssq_pkg::CMD_RESEL;
					d.dest = DEST_ID_I;
					d.pflag = 1'b0;
				end
			end
			ssq_pkg::ST_ARB: begin
				if (wr && code == ssq_pkg::CMD_PAUSE) begin
					d.pflag = 1'b1;
				end
				if (SELECTED_I || RESELECTED_I) begin
					// own command is forgotten entirely
					d.st = SELECTED_I ? ssq_pkg::ST_TGT
						: ssq_pkg::ST_INIT;
					d.arb = 1'b0;
					d.pflag = 1'b0;
					d.i_sel = SELECTED_I;
					d.i_bsvc = SELECTED_I && ATN_IN_I;
					d.i_resel = !SELECTED_I;
				end else if (q.pflag) begin
					d.st = ssq_pkg::ST_DISC;
					d.arb = 1'b0;
					d.pflag = 1'b0;
					d.paused = 1'b1;
				end else if (ARB_WON_I) begin
					d.st = ssq_pkg::ST_SELP;
					d.sel_out = 1'b1;
					d.id_drv = 1'b1;
					d.atn = q.atn_sel;
					d.tick = '0;
					d.to_en = q.tc != '0;
				end
			end
			ssq_pkg::ST_SELP: begin
				d.tick = q.tick + 1'b1;
				if (wr && code == ssq_pkg::CMD_PAUSE) begin
					d.pflag = 1'b1;
				end
				if (BSY_IN_I) begin
					// target answered: the selection is done
					d.st = q.resel ? ssq_pkg::ST_TGT
						: ssq_pkg::ST_INIT;
					d.i_fc = 1'b1;
					d.pflag = 1'b0;
					d.arb = 1'b0;
					d.sel_out = 1'b0;
					d.id_drv = 1'b0;
				end else if (q.to_en && q.tick ==
					ssq_pkg::TICK_W'(ssq_pkg::TICK_CYC - 1)) begin
					d.tc = q.tc - 1'b1;
					if (q.tc == ssq_pkg::TC_W'(1)) begin
						d = RST;
						d.i_disc = 1'b1;
					end
				end else if (q.pflag) begin
					// drop the ids, keep selection on for the hold
					d.st = ssq_pkg::ST_PHOLD;
					d.id_drv = 1'b0;
					d.atn = 1'b0;
					d.hold = '0;
				end
			end
			ssq_pkg::ST_PHOLD: begin
				d.hold = q.hold + 1'b1;
				if (q.hold == ssq_pkg::HOLD_W'(ssq_pkg::HOLD_CYC - 1))
				begin
					d.st = ssq_pkg::ST_PBSY;
				end
			end
			ssq_pkg::ST_PBSY: begin
				// only release once nobody holds busy
				if (!BSY_IN_I) begin
					d.st = ssq_pkg::ST_DISC;
					d.sel_out = 1'b0;
					d.arb = 1'b0;
					d.pflag = 1'b0;
					d.paused = 1'b1;
				end
			end
			ssq_pkg::ST_INIT: begin
				// clear first: a last byte in the accept cycle keeps ack
				if (wr && code == ssq_pkg::CMD_MSGACC) begin
					d.ack_hold = 1'b0;
				end
				if (MSGIN_LAST_I) begin
					d.i_fc = 1'b1;
					d.ack_hold = 1'b1;
				end
				if (MSGOUT_DONE_I) begin
					d.atn = 1'b0;
				end
				// a set request in the same cycle wins over the clear
				if (PAR_ERR_I || (wr && code == ssq_pkg::CMD_SETATN))
				begin
					d.atn = 1'b1;
				end
			end
			ssq_pkg::ST_TGT: begin
				// the count moves one per byte; a pause stops it at
				// a byte edge so it keeps the remaining length
				if (XFER_ACTIVE_I && BYTE_DONE_I && q.tc != '0) begin
					d.tc = q.tc - 1'b1;
				end
				if (wr && code == ssq_pkg::CMD_PAUSE) begin
					d.pflag = 1'b1;
				end
				if (q.pflag && ATN_IN_I) begin
					d.pflag = 1'b0;
					d.i_bsvc = 1'b1;
				end else if (q.pflag &&
					(BYTE_DONE_I || !XFER_ACTIVE_I)) begin
					d.pflag = 1'b0;
					d.abort = XFER_ACTIVE_I;
					d.paused = 1'b1;
				end
			end
			ssq_pkg::ST_OFF: begin
				d = q;
				d.i_fc = 1'b0;
				d.i_disc = 1'b0;
				d.i_inv = 1'b0;
				d.i_sel = 1'b0;
				d.i_resel = 1'b0;
				d.i_bsvc = 1'b0;
				d.abort = 1'b0;
			end
			default: d = RST;
		endcase
		// commands decoded here for every live state; disconnect acts only as initiator or target
		if (wr && q.st != ssq_pkg::ST_OFF) begin
			if (code == ssq_pkg::CMD_DISC &&
				(q.st == ssq_pkg::ST_INIT || q.st == ssq_pkg::ST_TGT))
			begin
				d = RST;
			end else if (code == ssq_pkg::CMD_DISABLE) begin
				d = RST;
				d.st = ssq_pkg::ST_OFF;
				d.oe = 1'b0;
			end else if (!is_imm(code) && (code > ssq_pkg::INT_LAST ||
				(is_sel(code) && q.st != ssq_pkg::ST_DISC))) begin
				d.i_inv = 1'b1;
			end
		end
		// chip reset overrides everything, disabled state included
		if (wr && code == ssq_pkg::CMD_RESET) begin
			d = RST;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			q <= RST;
		end else if (CE_I) begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs, all straight from the state record
	assign STATE_O = q.st;
	assign BUS_OE_O = q.oe;
	assign ARB_REQ_O = q.arb;
	assign SEL_OUT_O = q.sel_out;
	assign ID_DRV_O = q.id_drv;
	assign DEST_ID_O = q.dest;
	assign ATN_O = q.atn;
	assign ACK_HOLD_O = q.ack_hold;
	assign XFER_ABORT_O = q.abort;
	assign PAUSED_O = q.paused;
	assign TC_O = q.tc;
	assign INT_FC_O = q.i_fc;
	assign INT_DISC_O = q.i_disc;
	assign INT_INV_O = q.i_inv;
	assign INT_SEL_O = q.i_sel;
	assign INT_RESEL_O = q.i_resel;
	assign INT_BSVC_O = q.i_bsvc;

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	// cycles with selection driven and ids dropped
	logic [ssq_pkg::HOLD_W:0] hold_seen;
	always_ff @(posedge CLK_I) begin
		if (!NRST_I || !SEL_OUT_O || ID_DRV_O) begin
			hold_seen <= '0;
		end else if (&hold_seen == 1'b0) begin
			hold_seen <= hold_seen + 1'b1;
		end
	end

	sequence s_cmd(logic [4:0] c);
		CE_I && wr && code == c;
	endsequence
	sequence s_arb_pause;
		CE_I && q.st == ssq_pkg::ST_ARB && q.pflag && !SELECTED_I &&
			!RESELECTED_I && !wr;
	endsequence
	sequence s_tgt_pause;
		CE_I && q.st == ssq_pkg::ST_TGT && q.pflag && !ATN_IN_I &&
			BYTE_DONE_I && XFER_ACTIVE_I && !wr;
	endsequence

	chk_reset_cmd: assert property (s_cmd(ssq_pkg::CMD_RESET) |=>
		STATE_O == ssq_pkg::ST_DISC && !SEL_OUT_O && !ATN_O && BUS_OE_O)
		else $error("chip reset did not clear state");
	chk_disc_release: assert property (s_cmd(ssq_pkg::CMD_DISC) &&
		(q.st == ssq_pkg::ST_INIT || q.st == ssq_pkg::ST_TGT) |=>
		STATE_O == ssq_pkg::ST_DISC && !ATN_O && !ACK_HOLD_O)
		else $error("disconnect did not release the bus");
	chk_pause_init: assert property (s_cmd(ssq_pkg::CMD_PAUSE) &&
		q.st == ssq_pkg::ST_INIT |=> !PAUSED_O)
		else $error("pause accepted as initiator");
	chk_tgt_pause: assert property (s_tgt_pause |=>
		PAUSED_O && XFER_ABORT_O && STATE_O == ssq_pkg::ST_TGT)
		else $error("target pause not taken at byte end");
	chk_arb_pause: assert property (s_arb_pause |=>
		PAUSED_O && STATE_O == ssq_pkg::ST_DISC && !ARB_REQ_O)
		else $error("pause before win not honoured");
	chk_hold_time: assert property ($rose(PAUSED_O) &&
		$past(q.st) == ssq_pkg::ST_PBSY |->
		$past(hold_seen) >= ssq_pkg::HOLD_CYC)
		else $error("selection hold shorter than minimum");
	chk_atn_wins: assert property (CE_I && q.st == ssq_pkg::ST_TGT &&
		q.pflag && ATN_IN_I && !wr |=> INT_BSVC_O && !PAUSED_O)
		else $error("pause beat a bus service event");
	chk_setatn: assert property (s_cmd(ssq_pkg::CMD_SETATN) &&
		q.st == ssq_pkg::ST_INIT |=> ATN_O)
		else $error("set attention not applied");
	chk_parity_atn: assert property (CE_I && !wr &&
		q.st == ssq_pkg::ST_INIT && PAR_ERR_I |=> ATN_O)
		else $error("parity error left attention off");
	chk_msgin_ack: assert property (CE_I && !wr &&
		q.st == ssq_pkg::ST_INIT && MSGIN_LAST_I |=> INT_FC_O ##0
		ACK_HOLD_O)
		else $error("message in end not flagged");
	chk_msgacc: assert property (s_cmd(ssq_pkg::CMD_MSGACC) &&
		q.st == ssq_pkg::ST_INIT && !MSGIN_LAST_I |=> !ACK_HOLD_O)
		else $error("message accepted kept ack");
	chk_disable: assert property (q.st == ssq_pkg::ST_OFF &&
		!(wr && code == ssq_pkg::CMD_RESET) |=>
		STATE_O == ssq_pkg::ST_OFF && !BUS_OE_O && !INT_INV_O)
		else $error("disabled state left without reset");
	chk_inv_sel: assert property (CE_I && wr && is_sel(code) &&
		(q.st == ssq_pkg::ST_INIT || q.st == ssq_pkg::ST_TGT) |=>
		INT_INV_O)
		else $error("select outside idle not refused");
	chk_tmo_off: assert property (q.st == ssq_pkg::ST_SELP &&
		!q.to_en |=> !INT_DISC_O)
		else $error("timeout fired with zero count");
	chk_sel_resp: assert property (CE_I && !wr && BSY_IN_I &&
		q.st == ssq_pkg::ST_SELP |=> INT_FC_O && !SEL_OUT_O)
		else $error("selection response not completed");
endmodule

`default_nettype wire

// *** verification/ssq_bus_model.sv ***
/*
 * far-side model of the shared bus: an arbiter that grants the bus on
 * request and a destination that raises busy when it is selected.
 * assumes the bench decides per scenario whether arbitration is won and
 * whether the destination answers; everything is synchronous to clk_i.
 */
`default_nettype none

module ssq_bus_model (
	input wire logic clk_i, // core clock
	input wire logic win_i, // grant arbitration when requested
	input wire logic resp_i, // destination answers selection
	input wire logic arb_req_i, // sequencer asks for the bus
	input wire logic sel_out_i, // selection_out_drive from sequencer
	input wire logic id_drv_i, // id bits on the bus
	output logic arb_won_o, // arbitration won
	output logic bsy_o // busy_in_sense seen by sequencer
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// responses
	initial begin
		arb_won_o = 1'b0;
		bsy_o = 1'b0;
	end

	// answer just after each edge, like every other bus party
	always @(posedge clk_i) begin
		#10;
		arb_won_o = win_i && arb_req_i;
		// busy is terminated, so a released line reads inactive low
		bsy_o = resp_i && sel_out_i && id_drv_i;
	end
endmodule

`default_nettype wire

// *** verification/test_ssq_sequencer.sv ***
/*
 * self-checking bench for the command sequencer: commands are driven by
 * tasks, sense pulses set inline around a tick, results compared against fixed values.
 * assumes the bus model sits on the arbitration and busy lines.
 */
`default_nettype none

module test_ssq_sequencer;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// signals
	logic clk = 1'b0; // 100 ns clock
	logic nrst_n = 1'b0; // reset, active low
	logic ce = 1'b1; // clock enable into the sequencer
	logic cmd_wr = 1'b0, tc_load = 1'b0, sel_in = 1'b0, resel_in = 1'b0;
	logic atn_in = 1'b0, xfer = 1'b0, byte_done = 1'b0, mo_done = 1'b0;
	logic mi_last = 1'b0, par_err = 1'b0, win = 1'b0, resp = 1'b0;
	logic [7:0] cmd = 8'h0; // command image
	logic [23:0] tc = 24'h0; // counter load value
	logic [2:0] dest = 3'h0; // destination id
	logic arb_won, bsy, bus_oe, arb_req, sel_out, id_drv, atn, ack_hold;
	logic abort, paused, i_fc, i_disc, i_inv, i_sel, i_resel, i_bsvc;
	logic [2:0] state, dest_o;
	logic [23:0] tc_o;
	logic [5:0] ints; // all interrupt pulses
	int fail_count = 0, checked = 0, cyc = 0, n, hold, c;
	localparam int FC = 0, DSC = 1, INV = 2, SEL = 3, RSL = 4, BSV = 5;
	assign ints = {i_bsvc, i_resel, i_sel, i_inv, i_disc, i_fc};

	always #50 clk = ~clk;

	ssq_sequencer ssq_sequencer_i (.CLK_I(clk), .NRST_I(nrst_n),
		.CE_I(ce), .CMD_WR_I(cmd_wr), .CMD_I(cmd), .TC_LOAD_I(tc_load),
		.TC_I(tc), .DEST_ID_I(dest), .ARB_WON_I(arb_won),
		.SELECTED_I(sel_in), .RESELECTED_I(resel_in), .BSY_IN_I(bsy),
		.ATN_IN_I(atn_in), .XFER_ACTIVE_I(xfer), .BYTE_DONE_I(byte_done),
		.MSGOUT_DONE_I(mo_done), .MSGIN_LAST_I(mi_last),
		.PAR_ERR_I(par_err), .STATE_O(state), .BUS_OE_O(bus_oe),
		.ARB_REQ_O(arb_req), .SEL_OUT_O(sel_out), .ID_DRV_O(id_drv),
		.DEST_ID_O(dest_o), .ATN_O(atn), .ACK_HOLD_O(ack_hold),
		.XFER_ABORT_O(abort), .PAUSED_O(paused), .TC_O(tc_o),
		.INT_FC_O(i_fc), .INT_DISC_O(i_disc), .INT_INV_O(i_inv),
		.INT_SEL_O(i_sel), .INT_RESEL_O(i_resel), .INT_BSVC_O(i_bsvc));

	ssq_bus_model ssq_bus_model_i (.clk_i(clk), .win_i(win),
		.resp_i(resp), .arb_req_i(arb_req), .sel_out_i(sel_out),
		.id_drv_i(id_drv), .arb_won_o(arb_won), .bsy_o(bsy));

	// ==========================================================
	// tasks
	task automatic wrap_up;
		if (fail_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// inputs always move 10 ns after the rising edge; a strobe left up
	// by issue drops here, so back-to-back commands keep it high
	task automatic tick;
		cmd_wr = 1'b0;
		@(posedge clk);
		#10;
	endtask

	// the strobe stays up afterwards until the next tick or load
	task automatic issue(input logic [4:0] code);
		cmd_wr = 1'b1;
		cmd = {3'h0, code};
		@(posedge clk);
		#10;
	endtask

	task automatic load(input logic [23:0] v, input logic [2:0] id);
		tc_load = 1'b1;
		tc = v;
		dest = id;
		tick;
		tc_load = 1'b0;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time,
				got, exp);
		end
	endtask

	task automatic chk_st(input ssq_pkg::ssq_state_e e);
		chk({21'h0, state}, {21'h0, e});
	endtask

	// bounded wait for one interrupt pulse, which may already be up
	task automatic wait_int(input int idx, input int max);
		n = 0;
		while (ints[idx] !== 1'b1 && n < max) begin
			tick;
			n++;
		end
		chk({23'h0, ints[idx]}, 24'h1);
	endtask

	// hang guard: the whole sequence needs about 2100 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			wrap_up;
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		#10;
		nrst_n = 1'b1;
		chk_st(ssq_pkg::ST_DISC);
		chk(bus_oe, 24'h1);
		win = 1'b1;
		resp = 1'b1;
		load(24'h2, 3'h5);
		issue(ssq_pkg::CMD_SEL_ATN);
		chk(dest_o, 24'h5);
		wait_int(FC, 10);
		chk_st(ssq_pkg::ST_INIT);
		chk(atn, 24'h1);
		mo_done = 1'b1;
		tick;
		mo_done = 1'b0;
		chk(atn, 24'h0);
		issue(ssq_pkg::CMD_PAUSE);
		chk(paused, 24'h0);
		par_err = 1'b1;
		tick;
		par_err = 1'b0;
		chk(atn, 24'h1);
		// message out end drops attention too, so that the set
		// attention below has something to change
		mi_last = 1'b1;
		mo_done = 1'b1;
		tick;
		mi_last = 1'b0;
		mo_done = 1'b0;
		wait_int(FC, 2);
		chk(ack_hold, 24'h1);
		chk(atn, 24'h0);
		issue(ssq_pkg::CMD_SETATN);
		chk(atn, 24'h1);
		issue(ssq_pkg::CMD_MSGACC);
		chk(ack_hold, 24'h0);
		issue(ssq_pkg::CMD_SEL);
		wait_int(INV, 2);
		issue(ssq_pkg::CMD_DISC);
		chk_st(ssq_pkg::ST_DISC);
		issue(ssq_pkg::CMD_DISC);
		chk(ints, 24'h0);
		issue(ssq_pkg::CMD_SETATN);
		chk(atn, 24'h0);
		issue(ssq_pkg::CMD_PAUSE);
		chk(paused, 24'h1);
		// no answer: one timeout interval of 1024 clocks
		resp = 1'b0;
		load(24'h1, 3'h3);
		issue(ssq_pkg::CMD_SEL);
		wait_int(DSC, 1100);
		chk(n >= 1020 && n <= 1030, 24'h1);
		chk_st(ssq_pkg::ST_DISC);
		// pause before arbitration is won
		win = 1'b0;
		load(24'h0, 3'h2);
		issue(ssq_pkg::CMD_SEL);
		issue(ssq_pkg::CMD_PAUSE);
		repeat (2) tick;
		chk_st(ssq_pkg::ST_DISC);
		chk(paused, 24'h1);
		// pause after the win, with the timeout disabled
		win = 1'b1;
		issue(ssq_pkg::CMD_SEL);
		tick;
		chk_st(ssq_pkg::ST_SELP);
		issue(ssq_pkg::CMD_PAUSE);
		n = 0;
		hold = 0;
		while (state !== 3'(ssq_pkg::ST_DISC) && n < 1200) begin
			tick;
			n++;
			if (sel_out === 1'b1 && id_drv === 1'b0) hold++;
		end
		chk(hold >= 1000, 24'h1);
		chk(paused, 24'h1);
		chk(sel_out, 24'h0);
		// reselected while arbitrating: own command forgotten
		win = 1'b0;
		issue(ssq_pkg::CMD_RESEL);
		resel_in = 1'b1;
		tick;
		resel_in = 1'b0;
		wait_int(RSL, 2);
		chk(arb_req, 24'h0);
		issue(ssq_pkg::CMD_DISC);
		// selected while idle, then pause a running transfer
		sel_in = 1'b1;
		tick;
		sel_in = 1'b0;
		wait_int(SEL, 2);
		chk_st(ssq_pkg::ST_TGT);
		// a frozen clock enable must not take the command
		ce = 1'b0;
		issue(ssq_pkg::CMD_DISC);
		ce = 1'b1;
		chk_st(ssq_pkg::ST_TGT);
		issue(ssq_pkg::CMD_SETATN);
		chk(atn, 24'h0);
		load(24'h3, 3'h0);
		xfer = 1'b1;
		issue(ssq_pkg::CMD_PAUSE);
		chk(paused, 24'h0);
		byte_done = 1'b1;
		tick;
		byte_done = 1'b0;
		xfer = 1'b0;
		chk(abort, 24'h1);
		chk(paused, 24'h1);
		chk(tc_o, 24'h2);
		chk_st(ssq_pkg::ST_TGT);
		atn_in = 1'b1;
		issue(ssq_pkg::CMD_PAUSE);
		wait_int(BSV, 3);
		tick;
		chk(paused, 24'h0);
		atn_in = 1'b0;
		// disabled: deaf to commands and bus until reset
		issue(ssq_pkg::CMD_DISABLE);
		chk(bus_oe, 24'h0);
		issue(ssq_pkg::CMD_SEL);
		chk(ints, 24'h0);
		sel_in = 1'b1;
		tick;
		sel_in = 1'b0;
		chk(ints, 24'h0);
		chk_st(ssq_pkg::ST_OFF);
		issue(ssq_pkg::CMD_RESET);
		chk_st(ssq_pkg::ST_DISC);
		chk(bus_oe, 24'h1);
		// reset from a live state must clear a loaded counter
		load(24'h5, 3'h1);
		chk(tc_o, 24'h5);
		issue(ssq_pkg::CMD_RESET);
		chk(tc_o, 24'h0);
		// reserved immediate codes are silent, codes past the last valid one invalid
		for (c = 6; c < 8; c++) begin
			issue(5'(c));
			chk(ints, 24'h0);
		end
		for (c = 22; c < 32; c += 9) begin
			issue(5'(c));
			wait_int(INV, 2);
		end
		wrap_up;
	end
endmodule

`default_nettype wire
